/* File: pcc_pkg.sv */
// Package of constants for the PLL clock path configuration block
`default_nettype none
// What this block does and what it leaves to software
// R1 - Power field 00 runs PLL, 01 powers down
// R2 - Source bit 0 clear uses divider, set bypasses
// R3 - Source bit 1 set picks internal oscillator
// R4 - Divider field picks ratio two to six
// R5 - Staged values apply only on update write
// R6 - Calibration bit plus update starts calibration
// R7 - Software clears calibration bit before recalibrating
// R8 - Software keeps divider in path with internal oscillator
// R9 - Bypass only for sources below divider limit
// R10 - External slow oscillator: enable PLL, bypass divider
// R11 - Polarity bit clear positive, set negative
// R12 - Two-bit field sets antibacklash pulse width
// R13 - Phase detector compares reference and feedback counters
// R14 - Software programs PLL register range for loop
// R15 - Reset: PLL off, divide by four, external
// R16 - Update bit clears itself after transfer
package pcc_pkg;
  localparam logic [11:0] OFF_PLL_CTRL  = 12'h010;
  localparam logic [11:0] OFF_ABL_CTRL  = 12'h017;
  localparam logic [11:0] OFF_CAL_CTRL  = 12'h018;
  localparam logic [11:0] OFF_DIV_RATIO = 12'h1e0;
  localparam logic [11:0] OFF_DIST_SRC  = 12'h1e1;
  localparam logic [11:0] OFF_UPDATE    = 12'h232;
  localparam logic [11:0] OFF_STATUS    = 12'h234;
  localparam logic [7:0]  RST_PLL_CTRL  = 8'h01;
  localparam logic [7:0]  RST_ABL_CTRL  = 8'h00;
  localparam logic [7:0]  RST_CAL_CTRL  = 8'h00;
  localparam logic [7:0]  RST_DIV_RATIO = 8'h02;
  localparam logic [7:0]  RST_DIST_SRC  = 8'h00;
  localparam logic [1:0]  PWR_NORMAL    = 2'h0;
  localparam logic [1:0]  PWR_DOWN      = 2'h1;
  localparam int          POL_BIT       = 7;
  localparam int          BYPASS_BIT    = 0;
  localparam int          INTOSC_BIT    = 1;
  localparam int          CAL_BIT       = 0;
  localparam logic [7:0]  UPDATE_CODE   = 8'h01;
  localparam logic [2:0]  DIV_MIN_CODE  = 3'h0;
  localparam logic [2:0]  DIV_MAX_CODE  = 3'h4;
  localparam int          CAL_TIME_US   = 100;
  localparam int          CLK_MHZ       = 10;
  localparam int          CAL_CYCLES    = CAL_TIME_US * CLK_MHZ;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

/* File: pcc_clock_path.sv */
// PLL clock path configuration with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
module pcc_clock_path #(
  parameter int CAL_CYCLES = pcc_pkg::CAL_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ref_counter_out,
  input  wire logic        fb_counter_out,
  output logic             pll_power_down,
  output logic             int_osc_select,
  output logic             divider_bypass,
  output logic [2:0]       osc_divider_ratio,
  output logic             pfd_negative,
  output logic [1:0]       antibacklash_width,
  output logic             cal_running,
  output logic             pump_up,
  output logic             pump_down
);

  // Counter is 16 bits wide; longer runs would wrap
  if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_cal_check
    $error("CAL_CYCLES out of range");
  end

  // Staged (software visible) registers
  logic [7:0]  pll_ctrl_r;
  logic [7:0]  abl_ctrl_r;
  logic [7:0]  cal_ctrl_r;
  logic [7:0]  div_ratio_r;
  logic [7:0]  dist_src_r;
  logic        update_r;
  // Active copies
  logic [7:0]  act_pll_r;
  logic [7:0]  act_abl_r;
  logic [7:0]  act_div_r;
  logic [7:0]  act_src_r;
  logic        act_cal_r;
  logic [15:0] cal_cnt_r;
  logic        cal_done_r;

  // Write channel capture
  logic [11:0] wr_addr_r;
  logic [7:0]  wr_data_r;
  logic        wr_be_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic        wr_fire;
  logic        wr_ok;
  logic        rd_fire;

  function automatic logic known_addr(input logic [11:0] a);
    return (a == pcc_pkg::OFF_PLL_CTRL) || (a == pcc_pkg::OFF_ABL_CTRL) ||
           (a == pcc_pkg::OFF_CAL_CTRL) || (a == pcc_pkg::OFF_DIV_RATIO) ||
           (a == pcc_pkg::OFF_DIST_SRC) || (a == pcc_pkg::OFF_UPDATE) ||
           (a == pcc_pkg::OFF_STATUS);
  endfunction

  function automatic logic div_code_ok(input logic [7:0] v);
    return (v[2:0] >= pcc_pkg::DIV_MIN_CODE) && (v[2:0] <= pcc_pkg::DIV_MAX_CODE);
  endfunction

  // One write at a time; address and data taken in any order
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_ok   = known_addr(wr_addr_r);
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_addr_r     <= 12'h000;
    end else if (wr_fire) begin
      aw_held_r     <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      s_axi_awready <= 1'b0;
      // Offsets are word indices; byte address is four times the index
      wr_addr_r     <= {2'b00, s_axi_awaddr[11:2]};
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r     <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data_r    <= 8'h00;
      wr_be_r      <= 1'b0;
    end else if (wr_fire) begin
      w_held_r     <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data_r    <= s_axi_wdata[7:0];
      wr_be_r      <= s_axi_wstrb[0];
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_bvalid;
    end
  end

  // Write response; unmapped address answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pcc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Staged registers; only lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_ctrl_r  <= pcc_pkg::RST_PLL_CTRL; // R15
      abl_ctrl_r  <= pcc_pkg::RST_ABL_CTRL;
      cal_ctrl_r  <= pcc_pkg::RST_CAL_CTRL;
      div_ratio_r <= pcc_pkg::RST_DIV_RATIO; // R15
      dist_src_r  <= pcc_pkg::RST_DIST_SRC; // R15
    end else if (wr_fire && wr_be_r) begin
      unique case (wr_addr_r)
        pcc_pkg::OFF_PLL_CTRL:  pll_ctrl_r <= wr_data_r;
        pcc_pkg::OFF_ABL_CTRL:  abl_ctrl_r <= wr_data_r;
        pcc_pkg::OFF_CAL_CTRL:  cal_ctrl_r <= wr_data_r;
        // Unsupported ratio codes are ignored to keep the divider legal
        pcc_pkg::OFF_DIV_RATIO: begin
          if (div_code_ok(wr_data_r)) begin
            div_ratio_r <= wr_data_r; // R4
          end
        end
        pcc_pkg::OFF_DIST_SRC:  dist_src_r <= wr_data_r;
        default: ;
      endcase
    end
  end

  // Update request; set by 0x01 write, clears after transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      update_r <= 1'b0;
    end else if (wr_fire && wr_be_r && wr_addr_r == pcc_pkg::OFF_UPDATE &&
                 wr_data_r == pcc_pkg::UPDATE_CODE) begin
      update_r <= 1'b1; // R5
    end else begin
      update_r <= 1'b0; // R16
    end
  end

  // Transfer staged values into active set on update only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_pll_r <= pcc_pkg::RST_PLL_CTRL; // R15
      act_abl_r <= pcc_pkg::RST_ABL_CTRL;
      act_div_r <= pcc_pkg::RST_DIV_RATIO;
      act_src_r <= pcc_pkg::RST_DIST_SRC;
      act_cal_r <= 1'b0;
    end else if (update_r) begin
      act_pll_r <= pll_ctrl_r; // R5
      act_abl_r <= abl_ctrl_r;
      act_div_r <= div_ratio_r;
      act_src_r <= dist_src_r;
      act_cal_r <= cal_ctrl_r[pcc_pkg::CAL_BIT];
    end
  end

  // Calibration starts on rising active calibration bit; rearm needs a clear first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_cnt_r  <= 16'h0000;
      cal_done_r <= 1'b0;
    end else if (update_r && cal_ctrl_r[pcc_pkg::CAL_BIT] && !act_cal_r) begin
      cal_cnt_r  <= 16'(CAL_CYCLES); // R6 R7
      cal_done_r <= 1'b0;
    end else if (cal_cnt_r != 16'h0000) begin
      cal_cnt_r  <= cal_cnt_r - 16'h0001;
      cal_done_r <= (cal_cnt_r == 16'h0001);
    end
  end

  // Active configuration driven out of flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_power_down     <= 1'b1; // R15
      int_osc_select     <= 1'b0;
      divider_bypass     <= 1'b0;
      osc_divider_ratio  <= pcc_pkg::RST_DIV_RATIO[2:0];
      pfd_negative       <= 1'b0;
      antibacklash_width <= 2'h0;
      cal_running        <= 1'b0;
    end else begin
      // Codes other than normal leave the loop off, the safe side
      pll_power_down     <= act_pll_r[1:0] != pcc_pkg::PWR_NORMAL; // R1
      int_osc_select     <= act_src_r[pcc_pkg::INTOSC_BIT]; // R3
      divider_bypass     <= act_src_r[pcc_pkg::BYPASS_BIT]; // R2 R9
      osc_divider_ratio  <= act_div_r[2:0]; // R4
      pfd_negative       <= act_pll_r[pcc_pkg::POL_BIT]; // R11
      antibacklash_width <= act_abl_r[1:0]; // R12
      cal_running        <= cal_cnt_r != 16'h0000;
    end
  end

  // Phase detector: leading input pumps, both high resets; polarity swaps sense
  logic ref_q_r;
  logic fb_q_r;
  logic up_st_r;
  logic dn_st_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || pll_power_down) begin
      ref_q_r <= 1'b0;
      fb_q_r  <= 1'b0;
      up_st_r <= 1'b0;
      dn_st_r <= 1'b0;
    end else begin
      ref_q_r <= ref_counter_out;
      fb_q_r  <= fb_counter_out;
      if (up_st_r && dn_st_r) begin
        up_st_r <= 1'b0; // R13
        dn_st_r <= 1'b0;
      end else begin
        up_st_r <= up_st_r | (ref_counter_out & !ref_q_r); // R13
        dn_st_r <= dn_st_r | (fb_counter_out & !fb_q_r);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else begin
      pump_up   <= pfd_negative ? dn_st_r : up_st_r; // R11 R13
      pump_down <= pfd_negative ? up_st_r : dn_st_r;
    end
  end

  // Read channel; status shows active power-down, source, bypass, ratio and calibration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pcc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= known_addr({2'b00, s_axi_araddr[11:2]}) ?
                       pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
      unique case ({2'b00, s_axi_araddr[11:2]})
        pcc_pkg::OFF_PLL_CTRL:  s_axi_rdata <= {24'h000000, pll_ctrl_r};
        pcc_pkg::OFF_ABL_CTRL:  s_axi_rdata <= {24'h000000, abl_ctrl_r};
        pcc_pkg::OFF_CAL_CTRL:  s_axi_rdata <= {24'h000000, cal_ctrl_r};
        pcc_pkg::OFF_DIV_RATIO: s_axi_rdata <= {24'h000000, div_ratio_r};
        pcc_pkg::OFF_DIST_SRC:  s_axi_rdata <= {24'h000000, dist_src_r};
        pcc_pkg::OFF_UPDATE:    s_axi_rdata <= {31'h0, update_r};
        pcc_pkg::OFF_STATUS:    s_axi_rdata <= {24'h000000, cal_done_r,
                                  cal_running, pll_power_down, int_osc_select,
                                  divider_bypass, osc_divider_ratio};
        default:                s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: pcc_clock_path_sva.sv */
// Assertion checker for the PLL clock path configuration block
`timescale 1ns/10ps
`default_nettype none
module pcc_clock_path_sva #(
  parameter int CAL_CYCLES = 5
) (
  input wire logic       aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       ref_counter_out,
  input wire logic       fb_counter_out,
  input wire logic       pll_power_down,
  input wire logic       int_osc_select,
  input wire logic       divider_bypass,
  input wire logic [2:0] osc_divider_ratio,
  input wire logic       pfd_negative,
  input wire logic [1:0] antibacklash_width,
  input wire logic       cal_running,
  input wire logic       pump_up,
  input wire logic       pump_down
);
  logic       bv_q;
  logic       aw_upd_q;
  logic       w_upd_q;
  logic [2:0] since_b;
  int         cal_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Whether the write in flight is the update command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_upd_q <= 1'b0;
      w_upd_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        aw_upd_q <= s_axi_awaddr[11:2] == pcc_pkg::OFF_UPDATE[9:0];
      if (s_axi_wvalid && s_axi_wready)
        w_upd_q <= s_axi_wdata[7:0] == pcc_pkg::UPDATE_CODE;
    end
  end
  // Age of last update response; other writes must not excuse a change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q    <= 1'b0;
      since_b <= 3'h7;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_bvalid && !bv_q && aw_upd_q && w_upd_q)
        since_b <= 3'h0;
      else if (since_b != 3'h7)
        since_b <= since_b + 3'h1;
    end
  end
  // Length of the current calibration run
  always_ff @(posedge aclk) begin
    if (!aresetn || !cal_running)
      cal_cnt <= 0;
    else
      cal_cnt <= cal_cnt + 1;
  end
  // Leading edge on one detector input while the loop is powered
  sequence s_lead(logic a, logic b);
    $rose(a) && !b && !pll_power_down;
  endsequence
  property p_rst;
    disable iff (1'b0) !aresetn |=> pll_power_down && !int_osc_select && !divider_bypass
      && osc_divider_ratio == 3'h2 && !cal_running;
  endproperty
  property p_stage;
    $changed({pll_power_down, int_osc_select, divider_bypass, osc_divider_ratio,
      pfd_negative, antibacklash_width}) |-> since_b <= 3'h3;
  endproperty
  property p_cal_start;
    $rose(cal_running) |-> since_b <= 3'h3;
  endproperty
  property p_cal_len;
    $fell(cal_running) |-> cal_cnt == CAL_CYCLES;
  endproperty
  property p_pd;
    pll_power_down && $past(pll_power_down) && $past(pll_power_down, 2)
      |-> !pump_up && !pump_down;
  endproperty
  property p_up;
    s_lead(ref_counter_out, fb_counter_out) ##0 !pfd_negative |-> ##[1:4] pump_up;
  endproperty
  property p_dn;
    s_lead(ref_counter_out, fb_counter_out) ##0 pfd_negative |-> ##[1:4] pump_down;
  endproperty
  property p_ratio;
    osc_divider_ratio <= 3'h4;
  endproperty
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_stage: assert property (p_stage) else $error("config moved without update");
  a_cal_start: assert property (p_cal_start) else $error("calibration without update");
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  a_pd: assert property (p_pd) else $error("pump active while powered down");
  a_up: assert property (p_up) else $error("no pump up");
  a_dn: assert property (p_dn) else $error("no pump down");
  a_ratio: assert property (p_ratio) else $error("divider code out of range");
  a_bdone: assert property (p_bdone) else $error("response held after taken");
endmodule
bind pcc_clock_path pcc_clock_path_sva #(.CAL_CYCLES(CAL_CYCLES)) i_sva (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .ref_counter_out, .fb_counter_out,
  .pll_power_down, .int_osc_select, .divider_bypass, .osc_divider_ratio,
  .pfd_negative, .antibacklash_width, .cal_running, .pump_up, .pump_down);
`default_nettype wire

/* File: test_pcc_clock_path.sv */
// Testbench for the PLL clock path configuration block
`timescale 1ns/10ps
`default_nettype none
module test_pcc_clock_path;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ref_in, fb_in;
  logic        pd, osc, byp, neg, cal, up, dn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, abl;
  logic [2:0]  ratio;
  logic [8:0]  cfg;
  int          n_mismatch, checks;
  assign cfg = {pd, osc, byp, ratio, neg, abl};
  pcc_clock_path #(.CAL_CYCLES(5)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ref_counter_out(ref_in), .fb_counter_out(fb_in), .pll_power_down(pd),
    .int_osc_select(osc), .divider_bypass(byp), .osc_divider_ratio(ratio),
    .pfd_negative(neg), .antibacklash_width(abl), .cal_running(cal),
    .pump_up(up), .pump_down(dn));
  // Clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
  endtask
  // Update write, then room for the active copy to reach the pins
  // Byte addresses are four times the register index
  task automatic upd();
    wr(12'h8c8, 8'h01, 2'h0);
    repeat (3) @(posedge aclk);
  endtask
  // Drive detector inputs and look at the pumps once settled
  task automatic pulse(input logic r, input logic f, input logic [1:0] e);
    @(posedge aclk);
    ref_in <= r;
    fb_in <= f;
    repeat (4) @(posedge aclk);
    chk({30'h0, up, dn}, {30'h0, e});
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Generous bound; the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    results();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ref_in, fb_in} = 8'h00;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk({23'h0, cfg}, 32'h110);
    rd(12'h040, 8'h01, 2'h0);
    rd(12'h780, 8'h02, 2'h0);
    rd(12'h784, 8'h00, 2'h0);
    $display("test reset done");
    // External slow source: PLL on, divider bypassed
    wr(12'h040, 8'h80, 2'h0);
    wr(12'h784, 8'h01, 2'h0);
    wr(12'h05c, 8'h03, 2'h0);
    wr(12'h780, 8'h00, 2'h0);
    wr(12'h8c8, 8'h02, 2'h0);
    repeat (3) @(posedge aclk);
    chk({23'h0, cfg}, 32'h110);
    rd(12'h784, 8'h01, 2'h0);
    upd();
    chk({23'h0, cfg}, 32'h047);
    rd(12'h8c8, 8'h00, 2'h0);
    $display("test staging done");
    pulse(1'b1, 1'b0, 2'b01);
    pulse(1'b1, 1'b1, 2'b00);
    pulse(1'b0, 1'b0, 2'b00);
    wr(12'h040, 8'h00, 2'h0);
    upd();
    pulse(1'b1, 1'b0, 2'b10);
    pulse(1'b1, 1'b1, 2'b00);
    pulse(1'b0, 1'b0, 2'b00);
    // Reserved power code must also keep the loop off
    wr(12'h040, 8'h03, 2'h0);
    upd();
    chk({31'h0, pd}, 32'h1);
    pulse(1'b1, 1'b0, 2'b00);
    pulse(1'b0, 1'b0, 2'b00);
    $display("test detector done");
    wr(12'h784, 8'h00, 2'h0);
    for (int c = 0; c < 5; c++) begin
      wr(12'h780, c[7:0], 2'h0);
      upd();
      chk({27'h0, osc, byp, ratio}, c);
    end
    wr(12'h780, 8'h05, 2'h0);
    rd(12'h780, 8'h04, 2'h0);
    // Lane 0 strobe low: write is ignored
    wstrb <= 4'he;
    wr(12'h780, 8'h01, 2'h0);
    wstrb <= 4'hf;
    rd(12'h780, 8'h04, 2'h0);
    $display("test divider done");
    // Internal oscillator with divider kept in the path
    wr(12'h040, 8'h00, 2'h0);
    wr(12'h784, 8'h02, 2'h0);
    wr(12'h060, 8'h01, 2'h0);
    upd();
    chk({29'h0, pd, osc, byp}, 32'h2);
    chk({31'h0, cal}, 32'h1);
    repeat (8) @(posedge aclk);
    chk({31'h0, cal}, 32'h0);
    rd(12'h8d0, 8'h94, 2'h0);
    upd();
    chk({31'h0, cal}, 32'h0);
    wr(12'h060, 8'h00, 2'h0);
    upd();
    wr(12'h060, 8'h01, 2'h0);
    upd();
    chk({31'h0, cal}, 32'h1);
    repeat (8) @(posedge aclk);
    $display("test calibration done");
    wr(12'h400, 8'h55, 2'h2);
    rd(12'h400, 8'h00, 2'h2);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({23'h0, cfg}, 32'h110);
    rd(12'h040, 8'h01, 2'h0);
    $display("test errors and reset done");
    results();
  end
endmodule
`default_nettype wire
